// ---- bsf_pkg.sv ----
package bsf_pkg;

  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam int          CTRL_CLR_BIT   = 0;
  localparam int          CTRL_SYNC_BIT  = 1;
  localparam int          CTRL_THR_LSB   = 4;
  localparam int          STAT_ECG_OVF_BIT = 0;
  localparam int          STAT_IMP_OVF_BIT = 1;
  localparam int          STAT_FINT_BIT  = 2;
  localparam int          STAT_ECNT_LSB  = 8;
  localparam int          STAT_BCNT_LSB  = 16;
  localparam logic [2:0]  THR_RESET      = 3'h0;

  localparam int          ECG_DEPTH      = 32;
  localparam int          IMP_DEPTH      = 8;
  localparam int          WORD_W         = 24;
  localparam int          ECG_DATA_W     = 18;
  localparam int          IMP_DATA_W     = 20;

  localparam logic [2:0]  TAG_VALID      = 3'h0;
  localparam logic [2:0]  TAG_EMPTY      = 3'h6;
  localparam logic [2:0]  TAG_OVF        = 3'h7;

  localparam logic [9:0]  FIRST_ADV_EDGE = 10'h020;
  localparam logic [4:0]  BURST_STEP     = 5'h18;
  localparam logic [4:0]  BURST_MAX_N    = 5'h1f;

  typedef struct packed {
    logic [11:0] paddr;
    logic        pwrite;
    logic [31:0] pwdata;
    logic        psel;
    logic        penable;
  } bsf_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bsf_apb_rsp_s;

  typedef struct packed {
    logic [ECG_DATA_W-1:0] data;
    logic                  fast;
  } bsf_ecg_sample_s;

  typedef struct packed {
    logic [IMP_DATA_W-1:0] data;
    logic                  out_of_range;
  } bsf_imp_sample_s;

  // bit0 = channel flag (fast / out of range), bit1 = last entry; 10x never built
  function automatic logic [2:0] bsf_tag(input logic ovf, input logic empty,
                                         input logic flag, input logic last);
    logic [2:0] t;
    t = TAG_VALID;
    if (ovf)
      t = TAG_OVF;
    else if (empty)
      t = TAG_EMPTY;
    else
      t = {1'b0, last, flag};
    return t;
  endfunction

endpackage

// ---- bsf_sample_fifo.sv ----
`timescale 1ns/1ps
module bsf_sample_fifo #(
  parameter int DEPTH = 8,
  parameter int W     = 21
) (
  input  wire logic                       clk,
  input  wire logic                       rstn,
  input  wire logic                       clear,
  input  wire logic                       wr_en,
  input  wire logic [W-1:0]               wr_data,
  input  wire logic                       rd_adv,
  output logic      [W-1:0]               head,
  output logic      [$clog2(DEPTH):0]     count,
  output logic                            empty,
  output logic                            ovf
);
  import bsf_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    ovf;
  } bsf_fifo_s;

  bsf_fifo_s r_reg;
  bsf_fifo_s r_next;

  always_comb
  begin
    r_next = r_reg;
    if (clear)
    begin
      r_next.wp  = '0;
      r_next.rp  = '0;
      r_next.cnt = '0;
      r_next.ovf = 1'b0;
    end
    else if (rd_adv && r_reg.cnt != '0)
    begin
      // an entry once passed is gone for good
      r_next.rp  = r_reg.rp + 1'b1;
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    // a sample arriving with a clear lands in the freshly emptied buffer
    if (wr_en)
    begin
      if (r_next.cnt == (AW+1)'(DEPTH))
        r_next.ovf = 1'b1;
      else
      begin
        r_next.mem[r_next.wp] = wr_data;
        r_next.wp  = r_next.wp + 1'b1;
        r_next.cnt = r_next.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign head  = r_reg.mem[r_reg.rp];
  assign count = r_reg.cnt;
  assign empty = (r_reg.cnt == '0);
  assign ovf   = r_reg.ovf;

endmodule

// ---- bsf_link_edges.sv ----
`timescale 1ns/1ps
module bsf_link_edges (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic sclk_pin,
  input  wire logic csn_pin,
  input  wire logic sel_pin,
  input  wire logic burst_pin,
  output logic      adv,
  output logic      sel_imp
);
  import bsf_pkg::*;

  typedef struct packed {
    logic [1:0] sclk_s;
    logic       sclk_d;
    logic [1:0] csn_s;
    logic [1:0] sel_s;
    logic [1:0] bst_s;
    logic [9:0] edges;
    logic [4:0] step;
    logic [4:0] nburst;
    logic       adv;
  } bsf_link_s;

  bsf_link_s r_reg;
  bsf_link_s r_next;
  logic      rise;

  always_comb
  begin
    r_next        = r_reg;
    r_next.sclk_s = {r_reg.sclk_s[0], sclk_pin};
    r_next.csn_s  = {r_reg.csn_s[0], csn_pin};
    r_next.sel_s  = {r_reg.sel_s[0], sel_pin};
    r_next.bst_s  = {r_reg.bst_s[0], burst_pin};
    r_next.sclk_d = r_reg.sclk_s[1];
    r_next.adv    = 1'b0;
    rise          = r_reg.sclk_s[1] & ~r_reg.sclk_d;
    if (r_reg.csn_s[1])
    begin
      r_next.edges  = '0;
      r_next.step   = '0;
      r_next.nburst = '0;
    end
    else if (rise)
    begin
      if (r_reg.edges < FIRST_ADV_EDGE)
        r_next.edges = r_reg.edges + 1'b1;
      if (r_reg.edges + 1'b1 == FIRST_ADV_EDGE)
      begin
        r_next.adv  = 1'b1;
        r_next.step = '0;
      end
      else if (r_reg.edges == FIRST_ADV_EDGE && r_reg.bst_s[1]
               && r_reg.nburst < BURST_MAX_N)
      begin
        r_next.step = r_reg.step + 1'b1;
        if (r_reg.step + 1'b1 == BURST_STEP)
        begin
          r_next.adv    = 1'b1;
          r_next.step   = '0;
          r_next.nburst = r_reg.nburst + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      r_reg <= '{sclk_s: 2'h0, sclk_d: 1'b0, csn_s: 2'h3, sel_s: 2'h0, bst_s: 2'h0,
                 edges: 10'h000, step: 5'h00, nburst: 5'h00, adv: 1'b0};
    else
      r_reg <= r_next;
  end

  assign adv     = r_reg.adv;
  assign sel_imp = r_reg.sel_s[1];

endmodule

// ---- bsf_sample_fifo_tagging.sv ----
`timescale 1ns/1ps
// Operation
// - ecg tag sits in word bits 5..3.
// - ecg sample is 18-bit left-justified two's complement above the tag.
// - ecg sample taken in fast recovery is tagged 001.
// - valid ecg sample that is last in the fifo is tagged 010.
// - fast recovery ecg sample that is last in the fifo is tagged 011.
// - reading an empty ecg fifo returns tag 110.
// - ecg overflow returns tag 111 and sets the ecg overflow status flag.
// - overflow persists until the fifo clear command empties the fifo.
// - resync command restarts channel operation and resets all fifos.
// - impedance fifo is circular, 8 entries of 24 bits; entries here hold 21 bits, padded to 24 on read.
// - impedance fifo has separate read and write pointers; writes are internal.
// - normal read advances the impedance read pointer on sclk rising edge 32.
// - burst read advances on sclk edge 32 plus 24 times n, n up to 31.
// - an entry marked read is never returned again.
// - fill interrupt rises when unread count reaches threshold 1 to 8.
// - write pointer catching read pointer flags impedance overflow and tags.
// - impedance word: 20-bit sample, one zero bit, tag in bits 2..0.
// - valid impedance sample is tagged 000.
// - out-of-range impedance sample tagged 001, or 011 when last.
// - empty impedance fifo read returns tag 110.
// - impedance overflow returns tag 111.
module bsf_sample_fifo_tagging (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire bsf_pkg::bsf_apb_req_s     apb_req,
  output bsf_pkg::bsf_apb_rsp_s          apb_rsp,
  input  wire logic                      ecg_wr,
  input  wire bsf_pkg::bsf_ecg_sample_s  ecg_sample,
  input  wire logic                      imp_wr,
  input  wire bsf_pkg::bsf_imp_sample_s  imp_sample,
  input  wire logic                      link_sclk,
  input  wire logic                      link_csn,
  input  wire logic                      link_sel_imp,
  input  wire logic                      link_burst,
  output logic [bsf_pkg::WORD_W-1:0]     read_word,
  output logic                           ecg_overflow_flag,
  output logic                           impedance_overflow_flag,
  output logic                           impedance_fill_interrupt,
  output logic                           channel_restart
);
  import bsf_pkg::*;

  localparam int EW = ECG_DATA_W + 1;
  localparam int BW = IMP_DATA_W + 1;
  localparam int EC = $clog2(ECG_DEPTH) + 1;
  localparam int BC = $clog2(IMP_DEPTH) + 1;

  typedef struct packed {
    bsf_apb_rsp_s        rsp;
    logic [2:0]          thr;
    logic                fifo_clr;
    logic                restart;
    logic                ecg_flag;
    logic                imp_flag;
    logic                fint;
    logic [WORD_W-1:0]   word;
  } bsf_top_s;

  bsf_top_s        r_reg;
  bsf_top_s        r_next;

  logic            adv;
  logic            sel_imp;
  logic [EW-1:0]   ecg_head;
  logic [EC-1:0]   ecg_count;
  logic            ecg_empty;
  logic            ecg_ovf;
  logic [BW-1:0]   imp_head;
  logic [BC-1:0]   imp_count;
  logic            imp_empty;
  logic            imp_ovf;
  logic            ecg_adv;
  logic            imp_adv;
  logic            ecg_last;
  logic            imp_last;
  logic [2:0]      ecg_tag;
  logic [2:0]      imp_tag;
  logic [WORD_W-1:0] ecg_word;
  logic [WORD_W-1:0] imp_word;
  logic            access;
  logic            done;
  logic            hit_ctrl;
  logic            hit_stat;
  logic [31:0]     rdata;
  logic [BC-1:0]   thr_count;

  bsf_link_edges u_link (
    .clk       (pclk),
    .rstn      (presetn),
    .sclk_pin  (link_sclk),
    .csn_pin   (link_csn),
    .sel_pin   (link_sel_imp),
    .burst_pin (link_burst),
    .adv       (adv),
    .sel_imp   (sel_imp)
  );

  // only the selected fifo moves, and an empty one never does
  assign ecg_adv = adv & ~sel_imp & ~ecg_empty;
  assign imp_adv = adv & sel_imp & ~imp_empty;

  bsf_sample_fifo #(
    .DEPTH (ECG_DEPTH),
    .W     (EW)
  ) u_ecg_fifo (
    .clk     (pclk),
    .rstn    (presetn),
    .clear   (r_reg.fifo_clr),
    .wr_en   (ecg_wr),
    .wr_data (ecg_sample),
    .rd_adv  (ecg_adv),
    .head    (ecg_head),
    .count   (ecg_count),
    .empty   (ecg_empty),
    .ovf     (ecg_ovf)
  );

  bsf_sample_fifo #(
    .DEPTH (IMP_DEPTH),
    .W     (BW)
  ) u_imp_fifo (
    .clk     (pclk),
    .rstn    (presetn),
    .clear   (r_reg.fifo_clr),
    .wr_en   (imp_wr),
    .wr_data (imp_sample),
    .rd_adv  (imp_adv),
    .head    (imp_head),
    .count   (imp_count),
    .empty   (imp_empty),
    .ovf     (imp_ovf)
  );

  assign ecg_last = (ecg_count == EC'(1));
  assign imp_last = (imp_count == BC'(1));

  assign ecg_tag = bsf_tag(ecg_ovf, ecg_empty, ecg_head[0], ecg_last);
  assign imp_tag = bsf_tag(imp_ovf, imp_empty, imp_head[0], imp_last);

  // empty words carry no sample bits so stale data never leaks out
  always_comb
  begin
    ecg_word = '0;
    imp_word = '0;
    if (!ecg_empty)
      ecg_word[WORD_W-1 -: ECG_DATA_W] = ecg_head[EW-1:1];
    ecg_word[5:3] = ecg_tag;
    if (!imp_empty)
      imp_word[WORD_W-1 -: IMP_DATA_W] = imp_head[BW-1:1];
    imp_word[3]   = 1'b0;
    imp_word[2:0] = imp_tag;
  end

  // threshold field 0..7 stands for 1..8 unread entries
  assign thr_count = BC'(r_reg.thr) + BC'(1);

  assign access   = apb_req.psel & apb_req.penable;
  assign done     = access & r_reg.rsp.pready;
  assign hit_ctrl = (apb_req.paddr == ADDR_CTRL);
  assign hit_stat = (apb_req.paddr == ADDR_STATUS);

  always_comb
  begin
    rdata = '0;
    if (hit_ctrl)
      rdata[CTRL_THR_LSB +: 3] = r_reg.thr;
    else if (hit_stat)
    begin
      rdata[STAT_ECG_OVF_BIT]     = r_reg.ecg_flag;
      rdata[STAT_IMP_OVF_BIT]     = r_reg.imp_flag;
      rdata[STAT_FINT_BIT]        = r_reg.fint;
      rdata[STAT_ECNT_LSB +: EC]  = ecg_count;
      rdata[STAT_BCNT_LSB +: BC]  = imp_count;
    end
  end

  always_comb
  begin
    r_next             = r_reg;
    r_next.fifo_clr    = 1'b0;
    r_next.restart     = 1'b0;
    // one wait state: pready rises in the second access cycle
    r_next.rsp.pready  = access & ~r_reg.rsp.pready;
    r_next.rsp.pslverr = access & ~r_reg.rsp.pready & ~(hit_ctrl | hit_stat);
    r_next.rsp.prdata  = '0;
    if (access && !r_reg.rsp.pready && !apb_req.pwrite)
      r_next.rsp.prdata = rdata;
    if (done && apb_req.pwrite && hit_ctrl)
    begin
      r_next.thr = apb_req.pwdata[CTRL_THR_LSB +: 3];
      if (apb_req.pwdata[CTRL_CLR_BIT])
        r_next.fifo_clr = 1'b1;
      if (apb_req.pwdata[CTRL_SYNC_BIT])
      begin
        r_next.fifo_clr = 1'b1;
        r_next.restart  = 1'b1;
      end
    end
    // flags follow the fifos, which hold overflow until cleared
    r_next.ecg_flag = ecg_ovf;
    r_next.imp_flag = imp_ovf;
    r_next.fint = (imp_count >= thr_count);
    r_next.word = sel_imp ? imp_word : ecg_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '{rsp: '0, thr: THR_RESET, fifo_clr: 1'b0, restart: 1'b0,
                 ecg_flag: 1'b0, imp_flag: 1'b0, fint: 1'b0, word: '0};
    else
      r_reg <= r_next;
  end

  assign apb_rsp                  = r_reg.rsp;
  assign read_word                = r_reg.word;
  assign ecg_overflow_flag        = r_reg.ecg_flag;
  assign impedance_overflow_flag  = r_reg.imp_flag;
  assign impedance_fill_interrupt = r_reg.fint;
  assign channel_restart          = r_reg.restart;

endmodule

// ---- bsf_sample_fifo_tagging_properties.sv ----
`timescale 1ns/1ps
module bsf_sample_fifo_tagging_properties (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire bsf_pkg::bsf_apb_req_s       apb_req,
  input wire bsf_pkg::bsf_apb_rsp_s       apb_rsp,
  input wire logic                        ecg_wr,
  input wire logic                        imp_wr,
  input wire logic                        link_sel_imp,
  input wire logic [bsf_pkg::WORD_W-1:0]  read_word,
  input wire logic                        ecg_overflow_flag,
  input wire logic                        impedance_overflow_flag,
  input wire logic                        impedance_fill_interrupt,
  input wire logic                        channel_restart
);
  import bsf_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // a control write may move levels for a few cycles, so its age is tracked
  logic       ctrl_wr;
  logic [2:0] age_reg;
  logic [2:0] age_next;
  assign ctrl_wr = apb_rsp.pready && apb_req.pwrite && apb_req.paddr == ADDR_CTRL;
  always_comb
  begin
    age_next = age_reg;
    if (ctrl_wr)
      age_next = 3'h0;
    else if (age_reg != 3'h7)
      age_next = age_reg + 3'h1;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      age_reg <= 3'h7;
    else
      age_reg <= age_next;
  end
  a_tag_reserved: assert property (read_word[2:1] != 2'h2)
    else $error("reserved tag seen");
  a_imp_zero_bit: assert property (link_sel_imp [*8] |-> read_word[3] == 1'b0)
    else $error("impedance spare bit set");
  a_ecg_low_zero: assert property (!link_sel_imp [*8] |-> read_word[2:0] == 3'h0)
    else $error("ecg low bits set");
  a_imp_ovf_tag: assert property ((link_sel_imp && impedance_overflow_flag) [*8] |->
    read_word[2:0] == TAG_OVF)
    else $error("impedance overflow tag missing");
  a_ecg_ovf_tag: assert property ((!link_sel_imp && ecg_overflow_flag) [*8] |->
    read_word[5:3] == TAG_OVF)
    else $error("ecg overflow tag missing");
  a_ovf_held: assert property ($fell(impedance_overflow_flag) |-> age_reg < 3'h4)
    else $error("overflow dropped without clear");
  a_imp_ovf_cause: assert property ($rose(impedance_overflow_flag) |-> $past(imp_wr, 2))
    else $error("impedance overflow without write");
  a_ecg_ovf_cause: assert property ($rose(ecg_overflow_flag) |-> $past(ecg_wr, 2))
    else $error("ecg overflow without write");
  a_restart_pulse: assert property (ctrl_wr && apb_req.pwdata[CTRL_SYNC_BIT] |=>
    channel_restart ##1 !channel_restart)
    else $error("restart pulse wrong");
  a_restart_clears: assert property (channel_restart |-> ##2
    !impedance_overflow_flag && !ecg_overflow_flag)
    else $error("resync left overflow");
  a_irq_cause: assert property ($rose(impedance_fill_interrupt) |->
    $past(imp_wr, 2) || age_reg < 3'h4)
    else $error("fill interrupt without cause");
  c_imp_ovf: cover property ($rose(impedance_overflow_flag));
  c_restart: cover property (channel_restart);
  c_irq: cover property ($rose(impedance_fill_interrupt));
endmodule

bind bsf_sample_fifo_tagging bsf_sample_fifo_tagging_properties chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .ecg_wr(ecg_wr), .imp_wr(imp_wr), .link_sel_imp(link_sel_imp), .read_word(read_word),
  .ecg_overflow_flag(ecg_overflow_flag), .impedance_overflow_flag(impedance_overflow_flag),
  .impedance_fill_interrupt(impedance_fill_interrupt), .channel_restart(channel_restart)
);

// ---- bsf_spi_host.sv ----
`timescale 1ns/1ps
module bsf_spi_host (
  output logic link_sclk,
  output logic link_csn,
  output logic link_sel_imp,
  output logic link_burst
);
  initial
  begin
    link_sclk = 1'b0;
    link_csn = 1'b1;
    link_sel_imp = 1'b0;
    link_burst = 1'b0;
  end
  // sclk stands low between frames; the 3 ns skew keeps it off the pclk grid
  task automatic frame(input logic sel, input logic burst, input int edges);
    #3 link_sel_imp = sel;
    link_burst = burst;
    #20 link_csn = 1'b0;
    repeat (edges)
    begin
      #160 link_sclk = 1'b1;
      #160 link_sclk = 1'b0;
    end
    #200 link_csn = 1'b1;
  endtask
endmodule

// ---- bsf_sample_fifo_tagging_bench.sv ----
`timescale 1ns/1ps
module bsf_sample_fifo_tagging_bench;
  import bsf_pkg::*;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  bsf_apb_req_s    req = '0;
  bsf_apb_rsp_s    rsp;
  logic            ecg_wr = 1'b0;
  logic            imp_wr = 1'b0;
  bsf_ecg_sample_s ecg_s = '0;
  bsf_imp_sample_s imp_s = '0;
  logic            sclk;
  logic            csn;
  logic            sel;
  logic            burst;
  logic [23:0]     rword;
  logic            ecg_flag;
  logic            imp_flag;
  logic            irq;
  logic            restart;
  int              restart_count = 0;
  logic [31:0]     q;
  logic            e;
  int              errors = 0;
  int              samples_checked = 0;
  int              cycles = 0;

  bsf_spi_host host (.link_sclk(sclk), .link_csn(csn), .link_sel_imp(sel), .link_burst(burst));
  bsf_sample_fifo_tagging uut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ecg_wr(ecg_wr), .ecg_sample(ecg_s), .imp_wr(imp_wr), .imp_sample(imp_s),
    .link_sclk(sclk), .link_csn(csn), .link_sel_imp(sel), .link_burst(burst),
    .read_word(rword), .ecg_overflow_flag(ecg_flag), .impedance_overflow_flag(imp_flag),
    .impedance_fill_interrupt(irq), .channel_restart(restart)
  );

  always #20 pclk = ~pclk;

  // restart is a one-cycle pulse, so it is counted rather than sampled by a task
  always @(posedge pclk)
  begin
    if (restart === 1'b1)
      restart_count++;
  end

  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask

  // one idle edge after release so back-to-back calls never drive psel twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{paddr: a, pwrite: w, pwdata: d, psel: 1'b1, penable: 1'b0};
    @(posedge pclk);
    req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic push(input logic imp, input logic [19:0] d, input logic f);
    if (imp)
      imp_wr <= 1'b1;
    else
      ecg_wr <= 1'b1;
    imp_s <= {d, f};
    ecg_s <= {d[17:0], f};
    @(posedge pclk);
    imp_wr <= 1'b0;
    ecg_wr <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic word(input string what, input logic [23:0] exp);
    repeat (6) @(posedge pclk);
    check(what, {8'h0, exp}, {8'h0, rword});
  endtask

  task automatic rd(input logic s, input logic b, input int n, input string what,
                    input logic [23:0] exp);
    host.frame(s, b, n);
    word(what, exp);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl reset", 32'h0, q);
    apb(1'b1, ADDR_STATUS, 32'hffffffff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status ro", 32'h0, q);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped", 32'h1, {q[30:0], e});
  endtask

  task automatic t_imp();
    apb(1'b1, ADDR_CTRL, 32'h20);
    push(1'b1, 20'h80001, 1'b0);
    push(1'b1, 20'h7fffe, 1'b1);
    repeat (2) @(posedge pclk);
    check("irq two", 32'h0, {31'h0, irq});
    push(1'b1, 20'h12345, 1'b0);
    repeat (2) @(posedge pclk);
    check("irq three", 32'h1, {31'h0, irq});
    rd(1'b1, 1'b0, 0, "imp first", {20'h80001, 4'h0});
    rd(1'b1, 1'b0, 32, "imp range", {20'h7fffe, 4'h1});
    rd(1'b1, 1'b0, 31, "imp short", {20'h7fffe, 4'h1});
    rd(1'b1, 1'b0, 32, "imp last", {20'h12345, 4'h2});
    // last-entry tag seen: this read is the final one until new samples land
    rd(1'b1, 1'b0, 32, "imp empty", {20'h0, 4'h6});
    check("irq drained", 32'h0, {31'h0, irq});
    push(1'b1, 20'h54321, 1'b1);
    word("imp range last", {20'h54321, 4'h3});
  endtask

  task automatic t_burst();
    push(1'b1, 20'h00011, 1'b0);
    push(1'b1, 20'h00022, 1'b0);
    push(1'b1, 20'h00033, 1'b0);
    rd(1'b1, 1'b1, 80, "burst three", {20'h00033, 4'h2});
    rd(1'b1, 1'b0, 32, "burst drained", {20'h0, 4'h6});
  endtask

  task automatic t_imp_ovf();
    for (int i = 0; i < 8; i++)
      push(1'b1, 20'(i + 16), 1'b0);
    repeat (2) @(posedge pclk);
    check("imp full", 32'h0, {31'h0, imp_flag});
    push(1'b1, 20'h0f00f, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("imp ovf status", 32'h2, q & 32'h2);
    word("imp ovf tag", {20'h00010, 4'h7});
    rd(1'b1, 1'b0, 32, "imp ovf held", {20'h00011, 4'h7});
    apb(1'b1, ADDR_CTRL, 32'h1);
    word("imp cleared", {20'h0, 4'h6});
    check("imp ovf gone", 32'h0, {31'h0, imp_flag});
    check("clear no restart", 32'h0, restart_count);
  endtask

  task automatic t_ecg();
    push(1'b0, 20'h2aaaa, 1'b1);
    push(1'b0, 20'h15555, 1'b0);
    rd(1'b0, 1'b0, 0, "ecg fast", {18'h2aaaa, 6'h08});
    rd(1'b0, 1'b0, 32, "ecg last", {18'h15555, 6'h10});
    rd(1'b0, 1'b0, 32, "ecg empty", {18'h0, 6'h30});
    push(1'b0, 20'h3ffff, 1'b1);
    word("ecg fast last", {18'h3ffff, 6'h18});
    for (int i = 0; i < 32; i++)
      push(1'b0, 20'(i), 1'b0);
    word("ecg ovf tag", {18'h3ffff, 6'h38});
    check("ecg ovf flag", 32'h1, {31'h0, ecg_flag});
    apb(1'b1, ADDR_CTRL, 32'h2);
    word("ecg resync", {18'h0, 6'h30});
    apb(1'b0, ADDR_STATUS, 32'h0);
    check("status resync", 32'h0, q);
    check("restart pulse", 32'h1, restart_count);
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_regs();
    t_imp();
    t_burst();
    t_imp_ovf();
    t_ecg();
    finish_test();
  end
endmodule
